// ### hw/queue_regs_pkg.sv
// constants for the byte queue and bit-framing register block
// assumes a register port on one clock, byte-wide, already decoded host side
// Overview of operation
// (R1) 64-byte queue at one data port: write pushes, read pops oldest byte
// (R2) queue feeds transmit bytes and collects received bytes from bit stream
// (R3) read-only count in bits 6:0, up on write, down on read, resets 0
// (R4) level bit 7 written 1 clears pointers and overflow flag; reads 0
// (R5) near-full when free space is at or below six-bit threshold, reset 08h
// (R6) near-empty when stored byte count is at or below threshold
// (R7) control bit 7 stops timer, bit 6 starts it; both read 0
// (R8) control bits 2:0 give valid bits of last received byte; 0 = all
// (R9) framing bit 7 launches transmit; host uses it only under transceive
// (R10) rx alignment 6:4 picks first bit slot; overflow wraps to next byte
// (R11) host keeps rx alignment zero except bitwise anticollision at 106 kBd
// (R12) tx bits 2:0 give bits sent of final byte; 000b sends all eight
// (R13) modem state reads 001 while waiting for launch under transceive
// (R14) write to full queue is dropped, count kept, overflow flag set
// (R15) read of empty queue keeps count at zero, data undefined
package queue_regs_pkg;
	localparam logic [5:0] ADDR_DATA = 6'h09;
	localparam logic [5:0] ADDR_LEVEL = 6'h0a;
	localparam logic [5:0] ADDR_THRESH = 6'h0b;
	localparam logic [5:0] ADDR_CTRL = 6'h0c;
	localparam logic [5:0] ADDR_FRAME = 6'h0d;
	localparam int DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int CNT_W = 7;
	localparam logic [6:0] DEPTH_CNT = 7'h40;
	localparam int LEVEL_FLUSH_BIT = 7;
	localparam int CTRL_STOP_BIT = 7;
	localparam int CTRL_START_BIT = 6;
	localparam int FRAME_LAUNCH_BIT = 7;
	localparam int FRAME_ALIGN_LSB = 4;
	localparam int FRAME_LAST_LSB = 0;
	localparam logic [5:0] THRESH_RESET = 6'h08;
	localparam logic [7:0] CTRL_RESET = 8'h10;
	localparam logic [2:0] ALIGN_RESET = 3'h0;
	localparam logic [2:0] TX_LAST_RESET = 3'h0;
	typedef enum logic [2:0] {
		MS_IDLE = 3'h0,
		MS_WAIT_LAUNCH = 3'h1,
		MS_SENDING = 3'h3,
		MS_RECEIVING = 3'h6
	} modem_state_t;
endpackage

// ### hw/byte_store.sv
// 64-entry byte storage with pointers and fill count
// assumes caller never pushes and flushes in the same cycle expecting both
`timescale 1ns/1ps
module byte_store (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic push_in,
	input wire logic [7:0] push_data_in,
	input wire logic pop_in,
	input wire logic flush_in,
	output logic [7:0] head_out,
	output logic [6:0] count_out,
	output logic full_out,
	output logic empty_out
);
	logic [7:0] mem_q [queue_regs_pkg::DEPTH];
	logic [5:0] wr_q;
	logic [5:0] rd_q;
	logic [6:0] count_q;
	logic do_push;
	logic do_pop;

	assign full_out = count_q == queue_regs_pkg::DEPTH_CNT;
	assign empty_out = count_q == 7'h00;
	assign do_push = push_in && !full_out && !flush_in; // R14
	assign do_pop = pop_in && !empty_out && !flush_in; // R15
	assign head_out = mem_q[rd_q];
	assign count_out = count_q;

	always_ff @(posedge ref_clk_in) begin
		if (do_push) begin
			mem_q[wr_q] <= push_data_in; // R1
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || flush_in) begin
			wr_q <= 6'h00; // R4
			rd_q <= 6'h00;
			count_q <= 7'h00;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 6'h01;
			end
			if (do_pop) begin
				rd_q <= rd_q + 6'h01; // R1
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 7'h01; // R3
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 7'h01; // R3
			end
		end
	end
endmodule

// ### hw/rx_bit_packer.sv
// packs received serial bits into bytes starting at a chosen bit slot
// assumes one bit per valid pulse; a byte not taken before the next is lost
`timescale 1ns/1ps
module rx_bit_packer (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [2:0] rx_first_bit_position_in,
	input wire logic frame_start_in,
	input wire logic bit_valid_in,
	input wire logic bit_in,
	input wire logic frame_end_in,
	input wire logic byte_ready_in,
	output logic byte_valid_out,
	output logic [7:0] byte_out,
	output logic [2:0] rx_final_byte_valid_bits_out
);
	logic [7:0] acc_q;
	logic [2:0] pos_q;
	logic pending_q;
	logic [2:0] last_q;
	logic [7:0] acc_next;

	always_comb begin
		acc_next = acc_q;
		acc_next[pos_q] = bit_in;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			acc_q <= 8'h00;
			pos_q <= 3'h0;
			pending_q <= 1'b0;
		end else if (frame_start_in) begin
			acc_q <= 8'h00;
			pos_q <= rx_first_bit_position_in; // R10
			pending_q <= 1'b0;
		end else if (bit_valid_in) begin
			acc_q <= (pos_q == 3'h7) ? 8'h00 : acc_next;
			pos_q <= pos_q + 3'h1; // R10
			pending_q <= pos_q != 3'h7;
		end else if (frame_end_in) begin
			pending_q <= 1'b0;
			acc_q <= 8'h00;
		end
	end

	// full byte on slot 7, partial byte at frame end
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			byte_valid_out <= 1'b0;
			byte_out <= 8'h00;
		end else if (bit_valid_in && pos_q == 3'h7 && !frame_start_in) begin
			byte_valid_out <= 1'b1; // R2
			byte_out <= acc_next;
		end else if (frame_end_in && pending_q && !frame_start_in) begin
			byte_valid_out <= 1'b1; // R2
			byte_out <= acc_q;
		end else if (byte_ready_in) begin
			byte_valid_out <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			last_q <= 3'h0;
		end else if (frame_end_in && !frame_start_in) begin
			last_q <= pending_q ? pos_q : 3'h0; // R8
		end
	end
	assign rx_final_byte_valid_bits_out = last_q;
endmodule

// ### hw/byte_queue_and_bit_framing.sv
// register block for the byte queue, timer strobes and bit framing
// assumes the host interface delivers decoded one-cycle register strobes
`timescale 1ns/1ps
module byte_queue_and_bit_framing (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic transceive_active_in,
	input wire logic tx_byte_ready_in,
	output logic tx_byte_valid_out,
	output logic [7:0] tx_byte_out,
	output logic tx_final_byte_out,
	output logic [2:0] tx_final_byte_bit_count_out,
	output logic tx_launch_strobe_out,
	input wire logic rx_frame_start_in,
	input wire logic rx_bit_valid_in,
	input wire logic rx_bit_in,
	input wire logic rx_frame_end_in,
	output logic [2:0] rx_first_bit_position_out,
	output logic timer_halt_strobe_out,
	output logic timer_go_strobe_out,
	output logic near_full_flag_out,
	output logic near_empty_flag_out,
	output logic queue_overflow_error_out,
	output logic [2:0] modem_state_code_out
);
	logic [7:0] head;
	logic [6:0] stored_byte_count;
	logic full;
	logic empty;
	logic wr_data;
	logic rd_data;
	logic queue_clear_strobe;
	logic rx_byte_valid;
	logic [7:0] rx_byte;
	logic rx_byte_ready;
	logic push;
	logic [7:0] push_byte;
	logic pop;
	logic tx_take;
	logic [2:0] rx_final_byte_valid_bits;
	logic [5:0] warning_threshold_q;
	logic [2:0] rx_align_q;
	logic [2:0] tx_last_q;
	logic launch_q;
	logic halt_q;
	logic go_q;
	logic ovf_q;
	logic [7:0] rdata_q;
	logic [6:0] free_space;
	queue_regs_pkg::modem_state_t state_q;

	////////////////////////////////////////////////////////////////////
	// decode and queue
	assign wr_data = reg_wr_in && reg_addr_in == queue_regs_pkg::ADDR_DATA;
	assign rd_data = reg_rd_in && reg_addr_in == queue_regs_pkg::ADDR_DATA;
	assign queue_clear_strobe = reg_wr_in
		&& reg_addr_in == queue_regs_pkg::ADDR_LEVEL
		&& reg_wdata_in[queue_regs_pkg::LEVEL_FLUSH_BIT]; // R4
	// host port wins; receiver byte waits one cycle
	assign rx_byte_ready = !wr_data;
	assign push = wr_data || rx_byte_valid; // R2
	assign push_byte = wr_data ? reg_wdata_in : rx_byte;
	assign tx_take = tx_byte_valid_out && tx_byte_ready_in;
	assign pop = rd_data || tx_take; // R1

	byte_store i_byte_store (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.push_in(push),
		.push_data_in(push_byte),
		.pop_in(pop),
		.flush_in(queue_clear_strobe),
		.head_out(head),
		.count_out(stored_byte_count),
		.full_out(full),
		.empty_out(empty)
	);

	rx_bit_packer i_rx_bit_packer (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.rx_first_bit_position_in(rx_align_q),
		.frame_start_in(rx_frame_start_in),
		.bit_valid_in(rx_bit_valid_in),
		.bit_in(rx_bit_in),
		.frame_end_in(rx_frame_end_in),
		.byte_ready_in(rx_byte_ready),
		.byte_valid_out(rx_byte_valid),
		.byte_out(rx_byte),
		.rx_final_byte_valid_bits_out(rx_final_byte_valid_bits)
	);

	////////////////////////////////////////////////////////////////////
	// warnings and overflow
	assign free_space = queue_regs_pkg::DEPTH_CNT - stored_byte_count;
	assign near_full_flag_out = free_space <= {1'b0, warning_threshold_q}; // R5
	assign near_empty_flag_out =
		stored_byte_count <= {1'b0, warning_threshold_q}; // R6

	// a push to a full queue in the flush cycle still flags, set beats clear
	// a full push is dropped even beside a pop, so it flags as well
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			ovf_q <= 1'b0;
		end else if (push && full) begin
			ovf_q <= 1'b1; // R14
		end else if (queue_clear_strobe) begin
			ovf_q <= 1'b0; // R4
		end
	end
	assign queue_overflow_error_out = ovf_q;

	////////////////////////////////////////////////////////////////////
	// writable fields
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			warning_threshold_q <= queue_regs_pkg::THRESH_RESET;
		end else if (reg_wr_in
			&& reg_addr_in == queue_regs_pkg::ADDR_THRESH) begin
			warning_threshold_q <= reg_wdata_in[5:0]; // R5
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			rx_align_q <= queue_regs_pkg::ALIGN_RESET;
			tx_last_q <= queue_regs_pkg::TX_LAST_RESET;
		end else if (reg_wr_in
			&& reg_addr_in == queue_regs_pkg::ADDR_FRAME) begin
			rx_align_q <= reg_wdata_in[queue_regs_pkg::FRAME_ALIGN_LSB +: 3];
			tx_last_q <= reg_wdata_in[queue_regs_pkg::FRAME_LAST_LSB +: 3];
		end
	end
	assign rx_first_bit_position_out = rx_align_q; // R10
	assign tx_final_byte_bit_count_out = tx_last_q; // R12

	// strobes last one cycle after the write
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			halt_q <= 1'b0;
			go_q <= 1'b0;
			launch_q <= 1'b0;
		end else begin
			halt_q <= reg_wr_in && reg_addr_in == queue_regs_pkg::ADDR_CTRL
				&& reg_wdata_in[queue_regs_pkg::CTRL_STOP_BIT]; // R7
			go_q <= reg_wr_in && reg_addr_in == queue_regs_pkg::ADDR_CTRL
				&& reg_wdata_in[queue_regs_pkg::CTRL_START_BIT]; // R7
			launch_q <= reg_wr_in
				&& reg_addr_in == queue_regs_pkg::ADDR_FRAME
				&& reg_wdata_in[queue_regs_pkg::FRAME_LAUNCH_BIT]; // R9
		end
	end
	assign timer_halt_strobe_out = halt_q;
	assign timer_go_strobe_out = go_q;
	assign tx_launch_strobe_out = launch_q;

	////////////////////////////////////////////////////////////////////
	// modem sequencing; launch outside transceive is ignored
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !transceive_active_in) begin
			state_q <= queue_regs_pkg::MS_IDLE;
		end else begin
			case (state_q)
			queue_regs_pkg::MS_IDLE: begin
				state_q <= queue_regs_pkg::MS_WAIT_LAUNCH;
			end
			queue_regs_pkg::MS_WAIT_LAUNCH: begin
				if (launch_q) begin
					state_q <= queue_regs_pkg::MS_SENDING; // R9
				end
			end
			queue_regs_pkg::MS_SENDING: begin
				if (empty) begin
					state_q <= queue_regs_pkg::MS_RECEIVING;
				end
			end
			queue_regs_pkg::MS_RECEIVING: begin
				if (rx_frame_end_in) begin
					state_q <= queue_regs_pkg::MS_IDLE;
				end
			end
			default: begin
				state_q <= queue_regs_pkg::MS_IDLE;
			end
			endcase
		end
	end
	assign modem_state_code_out = state_q; // R13

	assign tx_byte_valid_out = state_q == queue_regs_pkg::MS_SENDING
		&& !empty && !rd_data; // R2
	assign tx_byte_out = head;
	assign tx_final_byte_out = stored_byte_count == 7'h01; // R12

	////////////////////////////////////////////////////////////////////
	// read data, one cycle after the read strobe
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
			queue_regs_pkg::ADDR_DATA: rdata_q <= head; // R15
			queue_regs_pkg::ADDR_LEVEL: begin
				rdata_q <= {1'b0, stored_byte_count}; // R3
			end
			queue_regs_pkg::ADDR_THRESH: begin
				rdata_q <= {2'b00, warning_threshold_q};
			end
			queue_regs_pkg::ADDR_CTRL: begin
				rdata_q <= queue_regs_pkg::CTRL_RESET
					| {5'h00, rx_final_byte_valid_bits}; // R8
			end
			queue_regs_pkg::ADDR_FRAME: begin
				rdata_q <= {1'b0, rx_align_q, 1'b0, tx_last_q};
			end
			default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign reg_rdata_out = rdata_q;

	////////////////////////////////////////////////////////////////////
	// checks
	sequence s_data_write_room;
		wr_data && !full && !pop && !queue_clear_strobe;
	endsequence

	property p_count_up;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		s_data_write_room |=> stored_byte_count
			== $past(stored_byte_count) + 7'h01;
	endproperty
	a_count_up: assert property (p_count_up) // R3
		else $error("count did not rise on write");

	property p_count_down;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		rd_data && !empty && !push && !queue_clear_strobe
			|=> stored_byte_count == $past(stored_byte_count) - 7'h01;
	endproperty
	a_count_down: assert property (p_count_down) // R3
		else $error("count did not fall on read");

	property p_flush;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		queue_clear_strobe && !(push && full)
			|=> stored_byte_count == 7'h00 && !ovf_q;
	endproperty
	a_flush: assert property (p_flush) // R4
		else $error("flush left data or overflow");

	property p_level_rd;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		reg_rd_in && reg_addr_in == queue_regs_pkg::ADDR_LEVEL
			|=> !reg_rdata_out[7] && reg_rdata_out[6:0]
			== $past(stored_byte_count);
	endproperty
	a_level_rd: assert property (p_level_rd) // R4
		else $error("level read wrong");

	property p_near_full;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		near_full_flag_out == (7'h40 - stored_byte_count
			<= {1'b0, warning_threshold_q});
	endproperty
	a_near_full: assert property (p_near_full) // R5
		else $error("near full flag wrong");

	property p_near_empty;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		near_empty_flag_out == (stored_byte_count
			<= {1'b0, warning_threshold_q});
	endproperty
	a_near_empty: assert property (p_near_empty) // R6
		else $error("near empty flag wrong");

	sequence s_halt_write;
		reg_wr_in && reg_addr_in == queue_regs_pkg::ADDR_CTRL
			&& reg_wdata_in[queue_regs_pkg::CTRL_STOP_BIT];
	endsequence

	// a second halt write right after the first may stretch the pulse
	property p_halt;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		s_halt_write |=> timer_halt_strobe_out ##1 (!timer_halt_strobe_out
			|| $past(reg_wr_in
			&& reg_addr_in == queue_regs_pkg::ADDR_CTRL
			&& reg_wdata_in[queue_regs_pkg::CTRL_STOP_BIT]));
	endproperty
	a_halt: assert property (p_halt) // R7
		else $error("halt strobe not one pulse");

	property p_overflow;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		wr_data && full && !pop |=> queue_overflow_error_out
			&& stored_byte_count == 7'h40;
	endproperty
	a_overflow: assert property (p_overflow) // R14
		else $error("full write not flagged");

	property p_wait_code;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		state_q == queue_regs_pkg::MS_WAIT_LAUNCH && transceive_active_in
			&& !launch_q |=> modem_state_code_out == 3'h1;
	endproperty
	a_wait_code: assert property (p_wait_code) // R13
		else $error("wait code not 001");

	property p_launch;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		state_q == queue_regs_pkg::MS_WAIT_LAUNCH && launch_q
			&& transceive_active_in
			|=> modem_state_code_out == 3'h3;
	endproperty
	a_launch: assert property (p_launch) // R9
		else $error("launch did not start send");
endmodule

// ### dv/modem_model.sv
// far-side modem model: takes transmit bytes, sends receive bit frames
// assumes it shares the block's clock and synchronous active-low reset
`timescale 1ns/1ps
module modem_model (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic tx_byte_valid_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_final_byte_in,
	output logic tx_byte_ready_out,
	output logic rx_frame_start_out,
	output logic rx_bit_valid_out,
	output logic rx_bit_out,
	output logic rx_frame_end_out
);
	logic [8:0] got_q[$];

	initial begin
		rx_frame_start_out = 1'b0;
		rx_bit_valid_out = 1'b0;
		rx_bit_out = 1'b0;
		rx_frame_end_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// ready every other cycle: a slow taker, so valid must hold meanwhile
	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			tx_byte_ready_out <= 1'b0;
		end else begin
			tx_byte_ready_out <= ~tx_byte_ready_out;
			if (tx_byte_valid_in && tx_byte_ready_out) begin
				got_q.push_back({tx_final_byte_in, tx_byte_in});
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bits go lsb first; idle data line toggles so stale values never pass
	task automatic rx_frame(input logic [7:0] b, input int n);
		@(posedge ref_clk_in);
		rx_frame_start_out <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_in);
			rx_frame_start_out <= 1'b0;
			rx_bit_valid_out <= 1'b1;
			rx_bit_out <= b[i];
		end
		@(posedge ref_clk_in);
		rx_bit_valid_out <= 1'b0;
		rx_bit_out <= ~rx_bit_out;
		rx_frame_end_out <= 1'b1;
		@(posedge ref_clk_in);
		rx_frame_end_out <= 1'b0;
	endtask
endmodule

// ### dv/byte_queue_and_bit_framing_tb.sv
// self-checking bench for the byte queue and bit-framing register block
// assumes the modem model on the far side and a 10 MHz clock
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
	end \
end
module byte_queue_and_bit_framing_tb;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [5:0] reg_addr_in = 6'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic transceive_active_in = 1'b0;
	logic [7:0] reg_rdata_out, tx_byte_out, rd_v;
	logic tx_byte_valid_out, tx_final_byte_out, tx_launch_strobe_out;
	logic [2:0] tx_final_byte_bit_count_out, rx_first_bit_position_out;
	logic timer_halt_strobe_out, timer_go_strobe_out, near_full_flag_out;
	logic near_empty_flag_out, queue_overflow_error_out;
	logic [2:0] modem_state_code_out;
	logic tx_ready, rx_start, rx_valid, rx_bit, rx_end;
	int errors = 0;
	int cmp_count = 0;

	always #50 ref_clk_in = ~ref_clk_in;

	////////////////////////////////////////////////////////////////////////
	byte_queue_and_bit_framing i_byte_queue_and_bit_framing (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out),
		.transceive_active_in(transceive_active_in),
		.tx_byte_ready_in(tx_ready), .tx_byte_valid_out(tx_byte_valid_out),
		.tx_byte_out(tx_byte_out), .tx_final_byte_out(tx_final_byte_out),
		.tx_final_byte_bit_count_out(tx_final_byte_bit_count_out),
		.tx_launch_strobe_out(tx_launch_strobe_out),
		.rx_frame_start_in(rx_start), .rx_bit_valid_in(rx_valid),
		.rx_bit_in(rx_bit), .rx_frame_end_in(rx_end),
		.rx_first_bit_position_out(rx_first_bit_position_out),
		.timer_halt_strobe_out(timer_halt_strobe_out),
		.timer_go_strobe_out(timer_go_strobe_out),
		.near_full_flag_out(near_full_flag_out),
		.near_empty_flag_out(near_empty_flag_out),
		.queue_overflow_error_out(queue_overflow_error_out),
		.modem_state_code_out(modem_state_code_out)
	);

	modem_model i_modem_model (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.tx_byte_valid_in(tx_byte_valid_out), .tx_byte_in(tx_byte_out),
		.tx_final_byte_in(tx_final_byte_out), .tx_byte_ready_out(tx_ready),
		.rx_frame_start_out(rx_start), .rx_bit_valid_out(rx_valid),
		.rx_bit_out(rx_bit), .rx_frame_end_out(rx_end)
	);

	////////////////////////////////////////////////////////////////////////
	// strobes held one cycle; checks land 1 ns after the taking edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		rd_v = reg_rdata_out;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	task test_done;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// whole run is about 300 cycles; twenty thousand means a hang
	initial begin
		settle(20000);
		errors++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		settle(1);
		`CHK({near_full_flag_out, near_empty_flag_out}, 2'b01)
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h00)
		rd(queue_regs_pkg::ADDR_THRESH);
		`CHK(rd_v, 8'h08)
		rd(queue_regs_pkg::ADDR_CTRL);
		`CHK(rd_v, 8'h10)
		rd(queue_regs_pkg::ADDR_FRAME);
		`CHK(rd_v, 8'h00)
		// fill to the brim, watching both warning flags at every level
		for (int i = 0; i < 64; i++) begin
			wr(queue_regs_pkg::ADDR_DATA, 8'(i));
			`CHK({near_full_flag_out, near_empty_flag_out}, {(63 - i) <= 8, i < 8})
		end
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h40)
		`CHK(queue_overflow_error_out, 1'b0)
		wr(queue_regs_pkg::ADDR_DATA, 8'hee);
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h40)
		`CHK(queue_overflow_error_out, 1'b1)
		for (int i = 0; i < 3; i++) begin
			rd(queue_regs_pkg::ADDR_DATA);
			`CHK(rd_v, 8'(i))
		end
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h3d)
		wr(queue_regs_pkg::ADDR_LEVEL, 8'h80);
		`CHK(queue_overflow_error_out, 1'b0)
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h00)
		rd(queue_regs_pkg::ADDR_DATA);
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h00)
		// lower threshold, reserved bits dropped, flags follow it
		wr(queue_regs_pkg::ADDR_THRESH, 8'hc4);
		rd(queue_regs_pkg::ADDR_THRESH);
		`CHK(rd_v, 8'h04)
		for (int i = 0; i < 5; i++) begin
			wr(queue_regs_pkg::ADDR_DATA, 8'(i));
			`CHK({near_full_flag_out, near_empty_flag_out}, {1'b0, i < 4})
		end
		// mid-run reset restores threshold and empties the queue
		@(posedge ref_clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		settle(1);
		rd(queue_regs_pkg::ADDR_THRESH);
		`CHK(rd_v, 8'h08)
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h00)
		// timer strobes one at a time, then quiet, then read back as 0
		for (int i = 0; i < 2; i++) begin
			wr(queue_regs_pkg::ADDR_CTRL, 8'h80 >> i);
			`CHK({timer_halt_strobe_out, timer_go_strobe_out}, 2'b10 >> i)
			settle(1);
			`CHK({timer_halt_strobe_out, timer_go_strobe_out}, 2'b00)
			rd(queue_regs_pkg::ADDR_CTRL);
			`CHK(rd_v, 8'h10)
		end
		// alignment stays zero outside anticollision
		wr(queue_regs_pkg::ADDR_FRAME, 8'h07);
		`CHK({rx_first_bit_position_out, tx_final_byte_bit_count_out}, 6'h07)
		`CHK(tx_launch_strobe_out, 1'b0)
		rd(queue_regs_pkg::ADDR_FRAME);
		`CHK(rd_v, 8'h07)
		// transmit two bytes under transceive
		wr(queue_regs_pkg::ADDR_DATA, 8'h5a);
		wr(queue_regs_pkg::ADDR_DATA, 8'hc3);
		wr(queue_regs_pkg::ADDR_FRAME, 8'h00);
		@(posedge ref_clk_in);
		transceive_active_in <= 1'b1;
		settle(3);
		`CHK(modem_state_code_out, 3'h1)
		`CHK(tx_byte_valid_out, 1'b0)
		wr(queue_regs_pkg::ADDR_FRAME, 8'h80);
		`CHK(tx_launch_strobe_out, 1'b1)
		for (int k = 0; k < 50 && i_modem_model.got_q.size() < 2; k++) begin
			settle(1);
		end
		`CHK(i_modem_model.got_q.size(), 2)
		`CHK(i_modem_model.got_q[0], 9'h05a)
		`CHK(i_modem_model.got_q[1], 9'h1c3)
		settle(3);
		`CHK(modem_state_code_out, 3'h6)
		// receive a whole byte, then a three-bit tail
		i_modem_model.rx_frame(8'ha5, 8);
		settle(3);
		rd(queue_regs_pkg::ADDR_LEVEL);
		`CHK(rd_v, 8'h01)
		rd(queue_regs_pkg::ADDR_DATA);
		`CHK(rd_v, 8'ha5)
		rd(queue_regs_pkg::ADDR_CTRL);
		`CHK(rd_v, 8'h10)
		i_modem_model.rx_frame(8'h05, 3);
		settle(3);
		rd(queue_regs_pkg::ADDR_CTRL);
		`CHK(rd_v, 8'h13)
		rd(queue_regs_pkg::ADDR_DATA);
		`CHK(rd_v & 8'h07, 8'h05)
		// nonzero alignment only as bitwise anticollision would use it
		wr(queue_regs_pkg::ADDR_FRAME, 8'h40);
		`CHK(rx_first_bit_position_out, 3'h4)
		rd(queue_regs_pkg::ADDR_FRAME);
		`CHK(rd_v, 8'h40)
		i_modem_model.rx_frame(8'ha5, 8);
		settle(3);
		rd(queue_regs_pkg::ADDR_DATA);
		`CHK(rd_v & 8'hf0, 8'h50)
		rd(queue_regs_pkg::ADDR_DATA);
		`CHK(rd_v & 8'h0f, 8'h0a)
		@(posedge ref_clk_in);
		transceive_active_in <= 1'b0;
		settle(3);
		`CHK(modem_state_code_out, 3'h0)
		test_done;
	end
endmodule
